// File: adcsp_pkg.sv
// Contract
// (R1) Self-clocked: chip select high mid-word floats data and clock after current bit.
// (R2) Self-clocked: chip select low again resumes with next bit, next computation period.
// (R3) Self-clocked: unfinished word at new word: ready high four clocks, then load.
// (R4) Self-clocked: data changes on falling serial clock, valid at rising edge.
// (R5) Mode pin low selects external-clock mode.
// (R6) External clock: chip select falling enables data output with MSB presented.
// (R7) External clock: host clocks; device advances each bit on falling edge.
// (R8) External clock: after LSB, float data-ready and serial data.
// (R9) External clock: new word during transfer with select low is discarded.
// (R10) External clock: chip select high floats serial data immediately.
// (R11) External clock: chip select low again continues with same bit.
// (R12) External clock: unfinished word, select high: ready high four clocks, then load.
// (R13) Self-clocked: transmit only inside digital computation periods.
// (R14) External clock: system should drive master clock from its own clock.
// (R15) Mode pin high selects self-clocked mode with internal serial clock.
// (R16) Interval is 16 periods of 64 clocks: eight settling, eight computation.
// (R17) Self-clocked: poll select at computation period start; if low, send MSB first.
// (R18) Self-clocked: after LSB, data-ready high until next word arrives.
// (R19) Word length is a design constant; shift runs MSB down through it.
// (R20) Self-clocked serial rate and placement derive from master clock.
package adcsp_pkg;

  localparam int WORD_BITS    = 20;
  localparam int SENT_W       = $clog2(WORD_BITS + 1);
  localparam int PERIOD_CLKS  = 64;
  localparam int PERIODS      = 16;
  localparam int IVL_W        = $clog2(PERIOD_CLKS * PERIODS);
  localparam int POS_W        = $clog2(PERIOD_CLKS);
  localparam int SCLK_HALF    = 2;
  localparam int PHASE_W      = $clog2(2 * SCLK_HALF);
  localparam int DATA_READY_N_HI_CLKS = 4;
  localparam int HOLD_W       = 3;
  localparam int SYNC_W       = 3;
  localparam int SYNC_MODE    = 0;
  localparam int SYNC_CS      = 1;
  localparam int SYNC_SCLK    = 2;

  localparam logic [POS_W-1:0]   LAST_BIT_START = POS_W'(PERIOD_CLKS - 1 - 2 * SCLK_HALF);
  localparam logic [PHASE_W-1:0] PH_RISE        = PHASE_W'(SCLK_HALF);
  localparam logic [PHASE_W-1:0] PH_END         = PHASE_W'(2 * SCLK_HALF - 1);
  localparam logic [HOLD_W-1:0]  HOLD_INIT      = HOLD_W'(DATA_READY_N_HI_CLKS);
  localparam logic [SENT_W-1:0]  SENT_LAST      = SENT_W'(WORD_BITS - 1);

  typedef enum logic [1:0] {ST_IDLE, ST_SSC_RUN, ST_SEC_RUN} adcsp_state_t;

endpackage

// File: adcsp_serial_port.sv
`timescale 1ns/1ps
module adcsp_serial_port
  import adcsp_pkg::*;
(
  input  wire logic                 core_clk,
  input  wire logic                 reset,
  input  wire logic                 mode_pin,
  input  wire logic                 cs_n,
  input  wire logic                 sclk_in,
  input  wire logic [WORD_BITS-1:0] word_in,
  input  wire logic                 word_load,
  output logic                      serial_data_out,
  output logic                      serial_data_oe_n,
  output logic                      sclk_out,
  output logic                      sclk_oe_n,
  output logic                      data_ready_n,
  output logic                      data_ready_oe_n
);

  // ****************************************
  // Synchronisers and interval timing
  // ****************************************
  logic [SYNC_W-1:0]    sync1_ff;
  logic [SYNC_W-1:0]    sync2_ff;
  logic [SYNC_W-1:0]    sync3_ff;
  logic [IVL_W-1:0]     ivl_ff;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      sync1_ff <= 3'h6;
      sync2_ff <= 3'h6;
      sync3_ff <= 3'h6;
      ivl_ff   <= '0;
    end else begin
      sync1_ff <= {sclk_in, cs_n, mode_pin};
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      ivl_ff   <= ivl_ff + 1'b1; // R16
    end
  end

  wire                  self_clocked_mode        = sync2_ff[SYNC_MODE]; // R5 R15
  wire                  cs_hi      = sync2_ff[SYNC_CS];
  wire                  cs_fall    = sync3_ff[SYNC_CS] & ~sync2_ff[SYNC_CS];
  wire                  sclk_fall  = sync3_ff[SYNC_SCLK] & ~sync2_ff[SYNC_SCLK];
  wire [POS_W-1:0]      pos        = ivl_ff[POS_W-1:0];
  // Odd periods compute, even periods settle
  wire                  in_digital = ivl_ff[POS_W]; // R16
  wire                  dig_start  = in_digital && (pos == '0);

  // ****************************************
  // Transfer state
  // ****************************************
  adcsp_state_t         state_ff;
  logic [WORD_BITS-1:0] shreg_ff;
  logic [WORD_BITS-1:0] pend_ff;
  logic [SENT_W-1:0]    sent_ff;
  logic [PHASE_W-1:0]   phase_ff;
  logic [HOLD_W-1:0]    hold_ff;
  logic                 word_ok_ff;
  logic                 sdo_ff;
  logic                 sdo_oe_n_ff;
  logic                 sclk_ff;
  logic                 sclk_oe_n_ff;
  logic                 data_ready_n_ff;
  logic                 data_ready_n_oe_n_ff;

  wire                  sec_busy   = ~self_clocked_mode && ~cs_hi && (state_ff == ST_SEC_RUN);
  wire                  accept     = word_load && !sec_busy; // R9
  wire                  last_bit   = (sent_ff == SENT_LAST);
  wire                  ssc_run    = (state_ff == ST_SSC_RUN);
  wire                  sec_run    = (state_ff == ST_SEC_RUN);
  wire                  bit_end    = ssc_run && (phase_ff == PH_END);
  wire                  no_room    = pos > LAST_BIT_START;
  wire                  ssc_start  = self_clocked_mode && dig_start && !cs_hi && word_ok_ff;
  wire                  sec_start  = ~self_clocked_mode && cs_fall && word_ok_ff;
  wire [WORD_BITS-1:0]  shifted    = {shreg_ff[WORD_BITS-2:0], 1'b0};

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_ff     <= ST_IDLE;
      shreg_ff     <= '0;
      pend_ff      <= '0;
      sent_ff      <= '0;
      phase_ff     <= '0;
      hold_ff      <= '0;
      word_ok_ff   <= 1'b0;
      sdo_ff       <= 1'b0;
      sdo_oe_n_ff  <= 1'b1;
      sclk_ff      <= 1'b1;
      sclk_oe_n_ff <= 1'b1;
      data_ready_n_ff      <= 1'b1;
      data_ready_n_oe_n_ff <= 1'b0;
    end else if (accept && word_ok_ff) begin
      // Unfinished word: ready high, then load the newcomer
      pend_ff      <= word_in; // R3 R12
      hold_ff      <= HOLD_INIT; // R3 R12
      word_ok_ff   <= 1'b0;
      data_ready_n_ff      <= 1'b1;
      data_ready_n_oe_n_ff <= 1'b0;
      state_ff     <= ST_IDLE;
      sdo_oe_n_ff  <= 1'b1;
      sclk_oe_n_ff <= 1'b1;
      sclk_ff      <= 1'b1;
    end else if (accept || (hold_ff == 3'h1)) begin
      shreg_ff     <= accept ? word_in : pend_ff;
      sent_ff      <= '0;
      hold_ff      <= '0;
      word_ok_ff   <= 1'b1;
      data_ready_n_ff      <= 1'b0;
      data_ready_n_oe_n_ff <= 1'b0;
      state_ff     <= ST_IDLE;
      sdo_oe_n_ff  <= 1'b1;
      sclk_oe_n_ff <= 1'b1;
      sclk_ff      <= 1'b1;
    end else begin
      if (hold_ff != '0) begin
        hold_ff <= hold_ff - 1'b1;
      end
      if (self_clocked_mode) begin
        data_ready_n_oe_n_ff <= 1'b0;
      end
      case (state_ff)
        ST_IDLE: begin
          if (ssc_start) begin
            // Fresh or interrupted word, current MSB goes first
            state_ff     <= ST_SSC_RUN; // R17 R2 R13
            phase_ff     <= '0;
            sclk_oe_n_ff <= 1'b0;
            sdo_oe_n_ff  <= 1'b0;
          end else if (sec_start) begin
            state_ff     <= ST_SEC_RUN;
            sdo_ff       <= shreg_ff[WORD_BITS-1]; // R6 R11
            sdo_oe_n_ff  <= 1'b0; // R6
          end
        end
        ST_SSC_RUN: begin
          phase_ff <= phase_ff + 1'b1;
          if (phase_ff == '0) begin
            sclk_ff <= 1'b0;
            sdo_ff  <= shreg_ff[WORD_BITS-1]; // R4 R19
          end else if (phase_ff == PH_RISE) begin
            sclk_ff <= 1'b1; // R4 R20
          end
          if (bit_end) begin
            phase_ff <= '0;
            shreg_ff <= shifted;
            sent_ff  <= sent_ff + 1'b1;
            if (last_bit) begin
              word_ok_ff <= 1'b0;
              data_ready_n_ff    <= 1'b1; // R18
            end
            if (last_bit || cs_hi || no_room) begin
              state_ff     <= ST_IDLE; // R1 R13
              sclk_oe_n_ff <= 1'b1; // R1
              sdo_oe_n_ff  <= 1'b1; // R1
            end
          end
        end
        ST_SEC_RUN: begin
          if (cs_hi) begin
            state_ff    <= ST_IDLE;
            sdo_oe_n_ff <= 1'b1; // R10
          end else if (sclk_fall) begin
            if (last_bit) begin
              state_ff     <= ST_IDLE;
              word_ok_ff   <= 1'b0;
              data_ready_n_ff      <= 1'b1;
              data_ready_n_oe_n_ff <= 1'b1; // R8
              sdo_oe_n_ff  <= 1'b1; // R8
            end else begin
              shreg_ff <= shifted; // R7
              sent_ff  <= sent_ff + 1'b1;
              sdo_ff   <= shreg_ff[WORD_BITS-2]; // R7
            end
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  assign serial_data_out  = sdo_ff;
  assign serial_data_oe_n = sdo_oe_n_ff;
  assign sclk_out         = sclk_ff;
  assign sclk_oe_n        = sclk_oe_n_ff;
  assign data_ready_n     = data_ready_n_ff;
  assign data_ready_oe_n  = data_ready_n_oe_n_ff;

  // ****************************************
  // Checks
  // ****************************************
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);

  sequence data_ready_n_hold_s;
    data_ready_n_ff [*4] ##1 !data_ready_n_ff;
  endsequence

  sequence sec_lsb_s;
    sec_run && !cs_hi && sclk_fall && last_bit;
  endsequence

  data_ready_n_pulse_a: assert property (accept && word_ok_ff |=> data_ready_n_hold_s) // R3 R12
    else $error("data ready pulse not four clocks");
  sec_cs_float_a: assert property (sec_run && cs_hi && !word_load |=> sdo_oe_n_ff) // R10
    else $error("data not floated on select high");
  sec_discard_a: assert property (word_load && sec_busy |=> !data_ready_n_ff && hold_ff == '0) // R9
    else $error("new word not discarded during transfer");
  ssc_digital_a: assert property (!sclk_oe_n_ff |-> $past(in_digital)) // R13
    else $error("serial clock driven outside computation period");
  ssc_data_fall_a: assert property ($changed(sdo_ff) && !sclk_oe_n_ff |-> !sclk_ff) // R4
    else $error("data changed away from falling clock");
  ssc_lsb_ready_a: assert property (bit_end && last_bit && !word_load |=> data_ready_n_ff && sclk_oe_n_ff) // R18
    else $error("ready not high after last bit");
  sec_lsb_float_a: assert property (sec_lsb_s |=> data_ready_n_oe_n_ff && sdo_oe_n_ff) // R8
    else $error("outputs not floated after last bit");
  sec_start_bit_a: assert property (sec_start && !word_load |=> // R6 R11
                                    !sdo_oe_n_ff && sdo_ff == $past(shreg_ff[WORD_BITS-1]))
    else $error("wrong bit presented on select fall");
  ssc_cs_stop_a: assert property (bit_end && cs_hi && !word_load |=> sclk_oe_n_ff && sdo_oe_n_ff) // R1
    else $error("outputs not floated after bit on select high");
  sec_advance_a: assert property (sec_run && !cs_hi && sclk_fall && !last_bit |=> // R7
                                  sdo_ff == $past(shreg_ff[WORD_BITS-2]))
    else $error("data did not advance on falling clock");

endmodule // adcsp_serial_port

// File: adcsp_host_model.sv
`timescale 1ns/1ps
module adcsp_host_model
  import adcsp_pkg::*;
(
  input  wire logic     core_clk,
  input  wire logic     mode_pin,
  input  wire logic     serial_data_out,
  input  wire logic     serial_data_oe_n,
  input  wire logic     sclk_out,
  input  wire logic     sclk_oe_n,
  output logic          sclk_in
);
  // ****************
  // Host capture
  // ****************
  logic [WORD_BITS-1:0] shift_ff;
  int                   bits_ff;
  logic                 last_ff;
  logic                 prev_ff;
  // Floating line shows inverse of last value
  wire  logic           data_wire = serial_data_oe_n ? ~last_ff : serial_data_out;
  initial begin
    sclk_in  = 1'b0;
    shift_ff = '0;
    bits_ff  = 0;
    last_ff  = 1'b0;
    prev_ff  = 1'b1;
  end
  task automatic clear();
    shift_ff = '0;
    bits_ff  = 0;
  endtask
  // Host clock idles low, runs only within frames; same master clock
  task automatic clock_bits(input int n);
    repeat (n) begin
      @(posedge core_clk) sclk_in <= 1'b1;
      shift_ff = {shift_ff[WORD_BITS-2:0], data_wire};
      bits_ff++;
      repeat (4) @(posedge core_clk);
      sclk_in <= 1'b0;
      repeat (4) @(posedge core_clk);
    end
  endtask
  always @(posedge core_clk) begin
    if (!serial_data_oe_n) last_ff <= serial_data_out;
    prev_ff <= sclk_out;
    if (mode_pin && !sclk_oe_n && sclk_out && !prev_ff) begin
      shift_ff <= {shift_ff[WORD_BITS-2:0], data_wire};
      bits_ff  <= bits_ff + 1;
    end
  end
endmodule // adcsp_host_model

// File: adc_serial_output_port_tb_top.sv
`timescale 1ns/1ps
module adc_serial_output_port_tb_top
  import adcsp_pkg::*;
;
  logic                 core_clk = 1'b0;
  logic                 reset = 1'b1;
  logic                 mode_pin = 1'b0;
  logic                 cs_n = 1'b1;
  logic                 word_load = 1'b0;
  logic [WORD_BITS-1:0] word_in = '0;
  logic                 serial_data_out, serial_data_oe_n, sclk_out, sclk_oe_n;
  logic                 data_ready_n, data_ready_oe_n, sclk_in;
  logic [31:0]          rng = 32'h00001ACB;
  logic [WORD_BITS-1:0] w;
  int                   miscompares = 0;
  int                   checks = 0;
  always #25 core_clk = ~core_clk;
  adcsp_serial_port dut (.core_clk(core_clk), .reset(reset), .mode_pin(mode_pin), .cs_n(cs_n),
    .sclk_in(sclk_in), .word_in(word_in), .word_load(word_load), .serial_data_out(serial_data_out),
    .serial_data_oe_n(serial_data_oe_n), .sclk_out(sclk_out), .sclk_oe_n(sclk_oe_n),
    .data_ready_n(data_ready_n), .data_ready_oe_n(data_ready_oe_n));
  adcsp_host_model host (.core_clk(core_clk), .mode_pin(mode_pin), .serial_data_out(serial_data_out),
    .serial_data_oe_n(serial_data_oe_n), .sclk_out(sclk_out), .sclk_oe_n(sclk_oe_n), .sclk_in(sclk_in));
  // ****************
  // Helpers
  // ****************
  function automatic logic [WORD_BITS-1:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng[WORD_BITS-1:0];
  endfunction
  task automatic check(input logic [WORD_BITS-1:0] seen, input logic [WORD_BITS-1:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic load(input logic [WORD_BITS-1:0] v);
    @(posedge core_clk) word_in <= v;
    word_load <= 1'b1;
    @(posedge core_clk) word_load <= 1'b0;
  endtask
  // Ready high four cycles after the load, low on the fifth
  function automatic logic exp_ready(input int k);
    return k < 5;
  endfunction
  task automatic reload_pulse();
    load(rnd());
    tick(3);
    w = rnd();
    load(w);
    for (int k = 1; k <= 5; k++) begin
      // First look lands in the cycle right after the load edge
      tick((k == 1) ? 0 : 1);
      check(data_ready_n, exp_ready(k));
    end
  endtask
  task automatic wait_on(input bit use_bits, input int n);
    int i;
    for (i = 0; i < 3000 && (use_bits ? host.bits_ff < n : data_ready_n !== 1'b1); i++) tick(1);
    if (i == 3000) begin
      miscompares++;
      report_and_stop();
    end
  endtask
  task automatic cs_set(input logic v, input int n);
    @(posedge core_clk) cs_n <= v;
    tick(n);
  endtask
  // ****************
  // Scenarios
  // ****************
  initial begin
    tick(10);
    reset <= 1'b0;
    w = rnd();
    load(w);
    tick(1);
    check(data_ready_n, 1'b0);
    host.clear();
    cs_set(1'b0, 8);
    check(serial_data_oe_n, 1'b0);
    check(serial_data_out, w[WORD_BITS-1]);
    host.clock_bits(8);
    cs_set(1'b1, 6);
    check(serial_data_oe_n, 1'b1);
    cs_set(1'b0, 8);
    load(rnd());
    host.clock_bits(WORD_BITS - 8);
    tick(6);
    check(host.shift_ff, w);
    check(serial_data_oe_n, 1'b1);
    check(data_ready_oe_n, 1'b1);
    cs_set(1'b1, 6);
    reload_pulse();
    host.clear();
    cs_set(1'b0, 8);
    host.clock_bits(WORD_BITS);
    tick(6);
    check(host.shift_ff, w);
    cs_set(1'b1, 6);
    @(posedge core_clk) mode_pin <= 1'b1;
    tick(6);
    reload_pulse();
    host.clear();
    cs_set(1'b0, 1);
    wait_on(1'b1, 8);
    cs_set(1'b1, 30);
    check(sclk_oe_n, 1'b1);
    check(serial_data_oe_n, 1'b1);
    cs_set(1'b0, 1);
    wait_on(1'b0, 0);
    tick(10);
    check(host.shift_ff, w);
    check(WORD_BITS'(host.bits_ff), WORD_BITS'(WORD_BITS));
    check(data_ready_n, 1'b1);
    report_and_stop();
  end
endmodule // adc_serial_output_port_tb_top
